// ===== mfe_pkg.sv
package mfe_pkg;

   // ****************************************************************
   // register map and field layout
   // ****************************************************************
   localparam logic [4:0] A_CTRL  = 5'h00;
   localparam logic [4:0] A_CFG   = 5'h04;
   localparam logic [4:0] A_LEN   = 5'h08;
   localparam logic [4:0] A_TXDAT = 5'h0c;
   localparam logic [4:0] A_STAT  = 5'h10;
   localparam logic [4:0] A_RXMSK = 5'h14;
   localparam logic [4:0] A_RXDAT = 5'h18;
   localparam logic [4:0] A_RXPTR = 5'h1c;
   localparam int B_START = 0;
   localparam int B_FIXED = 1;
   localparam int B_FSK   = 2;
   localparam int F_TID   = 0;
   localparam int F_IVL   = 10;
   localparam int F_CSZ   = 15;
   localparam int F_RTY   = 20;
   localparam int F_PAD   = 24;
   localparam logic [31:0] CFG_RST = 32'h0037_9000;

   // ****************************************************************
   // cell geometry and timing
   // ****************************************************************
   localparam logic [4:0] DSSS_MIN   = 5'h0f;
   localparam logic [4:0] DSSS_MAX   = 5'h17;
   localparam logic [4:0] FSK_MIN    = 5'h13;
   localparam logic [4:0] CSZ_MAX    = 5'h1f;
   localparam logic [4:0] ABORT_FNUM = 5'h00;
   localparam int IACK_CRC_W    = 16;
   localparam int CLK_PERIOD_NS = 50;

   // ****************************************************************
   // frame kinds, sender states, link beat
   // ****************************************************************
   typedef enum logic [2:0] {
      K_NONE   = 3'b000,
      K_CTX    = 3'b001,
      K_CELL   = 3'b010,
      K_CTXACK = 3'b011,
      K_IACK   = 3'b100
   } mfe_kind_e;

   typedef enum logic [2:0] {
      T_IDLE  = 3'b000,
      T_CTX   = 3'b001,
      T_SEL   = 3'b010,
      T_CELL  = 3'b011,
      T_WAIT  = 3'b100,
      T_ABORT = 3'b101
   } mfe_tx_e;

   typedef struct packed {
      logic        valid;
      mfe_kind_e   kind;
      logic        ar;
      logic [1:0]  ie_cnt;
      logic        has_tid;
      logic [9:0]  tid;
      logic [4:0]  fnum;
      logic        ext;
      logic [7:0]  data;
      logic        last;
      logic [4:0]  ival;
      logic [3:0]  iack_mask;
      logic [31:0] iack_flags;
      logic [31:0] crc;
   } mfe_frame_s;

endpackage

// ===== mfe_engine.sv
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Operation
// - one context element per frame
// - context asks ack, resent to limit
// - acked context starts cell flow
// - context bound to transaction id
// - receiver ends on fragment timeout
// - id zero: cells carry no id
// - cell: id, number, ext, data, check
// - unknown-id cells ignored
// - number zero: terminated
// - termination drops context
// - data placed by fragment number
// - extension bit reserved
// - cell size clamped per phy
// - all but last cell full
// - fixed mode pads last cell
// - wait ack; timeout resends last
// - cell retries spent: zero cell
// - context resets rx, is acked
// - resend only missing cells
// - ack: mask, flags, 16-bit check
// - mask bit n: set n; zero aborts
// - lowest set and fragment first
// - ack at last acked plus interval
// - resends first, then new cells
module mfe_engine
   import mfe_pkg::*;
#(
   parameter int          MEM_AW          = 10,
   parameter int          CRC_W           = 16,
   parameter logic [31:0] CRC_POLY        = 32'h0000_1021,
   parameter logic [15:0] IACK_POLY       = 16'h1021,
   parameter int          IACK_TIMEOUT_US = 1000,
   parameter int          FRAG_TIMEOUT_US = 100000
)(
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   input  wire logic [4:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output      logic [31:0] o_rdata,
   output      mfe_frame_s  o_tx,
   input  wire logic        i_tx_ready,
   input  wire mfe_frame_s  i_rx,
   output      mfe_frame_s  o_resp
);

   // ****************************************************************
   // timing and state
   // ****************************************************************
   // timeouts round down; a premature expiry only costs a resend
   localparam logic [31:0] IACK_CYC = 32'((64'(IACK_TIMEOUT_US)
      * 64'd1000) / 64'(CLK_PERIOD_NS));
   localparam logic [31:0] FRAG_CYC = 32'((64'(FRAG_TIMEOUT_US)
      * 64'd1000) / 64'(CLK_PERIOD_NS));

   typedef struct packed {
      mfe_tx_e           ts;
      logic              fixed;
      logic              fsk;
      logic [31:0]       cfg;
      logic [MEM_AW-1:0] len;
      logic [MEM_AW-1:0] wptr;
      logic [4:0]        ncells;
      logic [4:0]        cur;
      logic [5:0]        next_new;
      logic [4:0]        last_sent;
      logic [5:0]        isent;
      logic [4:0]        bi;
      logic              resend;
      logic [31:0]       sent;
      logic [31:0]       retry;
      logic [31:0]       crc;
      logic [31:0]       tmr;
      logic [3:0]        rty;
      logic              done;
      logic              err;
      mfe_frame_s        beat;
      logic              ract;
      logic [9:0]        rtid;
      logic [4:0]        rival;
      logic [4:0]        rtot;
      logic [5:0]        lack;
      logic [4:0]        rbi;
      logic [31:0]       rmask;
      logic [31:0]       rcrc;
      logic [31:0]       ftmr;
      logic              fto;
      mfe_frame_s        resp;
      logic [MEM_AW-1:0] rptr;
      logic [31:0]       rdata;
   } mfe_state_s;

   mfe_state_s        s_reg;
   mfe_state_s        s_next;
   logic [1:0]        rst_q;
   logic              rst_n;
   logic [7:0]        tx_mem [2**MEM_AW];
   logic [7:0]        rx_mem [2**MEM_AW];
   logic              tx_we;
   logic              rx_we;
   logic [MEM_AW-1:0] rx_wa;
   logic              start;
   logic              free;
   logic [4:0]        csz;
   logic [4:0]        cw;
   logic [4:0]        ival;
   logic [4:0]        pick;
   logic [31:0]       ofs;
   logic [31:0]       nc;
   logic [7:0]        byt;
   logic              lastb;
   logic [31:0]       pres;
   logic              match;
   logic [31:0]       rcrc_n;
   logic [3:0]        imask;
   logic [31:0]       iflags;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // msb-first; width and polynomial are parameters
   function automatic logic [31:0] crc_byte(input logic [31:0] c,
      input logic [7:0] d, input logic [31:0] poly, input int w);
      logic [31:0] r;
      logic        fb;
      r = c;
      for (int i = 0; i < 8; i++) begin
         fb = r[w-1] ^ d[7-i];
         r  = r << 1;
         if (fb) begin
            r = r ^ poly;
         end
      end
      return r & 32'((64'h1 << w) - 64'h1);
   endfunction

   // mask, then present sets, lowest first
   function automatic logic [31:0] iack_crc(input logic [3:0] m,
      input logic [31:0] f);
      logic [31:0] c;
      c = crc_byte(32'h0, {4'h0, m}, 32'(IACK_POLY), IACK_CRC_W);
      for (int n = 0; n < 4; n++) begin
         if (m[n]) begin
            c = crc_byte(c, f[8*n +: 8], 32'(IACK_POLY), IACK_CRC_W);
         end
      end
      return c;
   endfunction

   // ****************************************************************
   // reset release
   // ****************************************************************
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_q <= 2'b00;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      s_next  = s_reg;
      s_next.rdata = '0;
      s_next.resp  = '0;
      tx_we   = 1'b0;
      rx_we   = 1'b0;
      rx_wa   = '0;
      start   = 1'b0;
      csz     = s_reg.cfg[F_CSZ +: 5];
      ival    = s_reg.cfg[F_IVL +: 5];
      cw      = i_wdata[F_CSZ +: 5];
      pick    = '0;
      free    = !s_reg.beat.valid || i_tx_ready;
      nc      = (32'(s_reg.len) + 32'(csz) - 32'd1) / 32'(csz);
      ofs     = (32'(s_reg.cur) - 32'd1) * 32'(csz) + 32'(s_reg.bi);
      byt     = (ofs < 32'(s_reg.len)) ? tx_mem[MEM_AW'(ofs)]
                                       : s_reg.cfg[F_PAD +: 8];
      lastb   = (s_reg.cur != s_reg.ncells || s_reg.fixed)
                ? (s_reg.bi == csz - 5'd1)
                : (ofs + 32'd1 >= 32'(s_reg.len));
      pres    = {{8{i_rx.iack_mask[3]}}, {8{i_rx.iack_mask[2]}},
                 {8{i_rx.iack_mask[1]}}, {8{i_rx.iack_mask[0]}}};
      match   = s_reg.ract && i_rx.tid == s_reg.rtid;
      rcrc_n  = crc_byte(s_reg.rcrc, i_rx.data, CRC_POLY, CRC_W);
      imask   = '0;
      iflags  = '0;
      for (int k = 31; k > 0; k--) begin
         if (s_reg.retry[k]) begin
            pick = 5'(k); // lowest pending first
         end
      end
      if (s_reg.beat.valid && i_tx_ready) begin
         s_next.beat.valid = 1'b0;
      end

      // register writes; cell size clamped per phy
      if (i_wr) begin
         case (i_addr)
            A_CTRL: begin
               s_next.fixed = i_wdata[B_FIXED];
               s_next.fsk   = i_wdata[B_FSK];
               start        = i_wdata[B_START];
            end
            A_CFG: begin
               if (s_reg.fsk) begin
                  cw = (cw < FSK_MIN) ? FSK_MIN : cw;
               end else begin
                  cw = (cw < DSSS_MIN) ? DSSS_MIN
                     : (cw > DSSS_MAX) ? DSSS_MAX : cw;
               end
               s_next.cfg = {i_wdata[31:20], cw, i_wdata[14:0]};
               if (i_wdata[F_IVL +: 5] == 5'h00) begin
                  s_next.cfg[F_IVL +: 5] = 5'h01;
               end
            end
            A_LEN: begin
               s_next.len  = i_wdata[MEM_AW-1:0];
               s_next.wptr = '0;
            end
            A_TXDAT: begin
               tx_we       = 1'b1;
               s_next.wptr = s_reg.wptr + 1'b1;
            end
            A_RXPTR: s_next.rptr = i_wdata[MEM_AW-1:0];
            default: ;
         endcase
      end

      // register reads; the rx data port advances its pointer
      if (i_rd) begin
         case (i_addr)
            A_CTRL:  s_next.rdata = {29'h0, s_reg.fsk, s_reg.fixed, 1'b0};
            A_CFG:   s_next.rdata = s_reg.cfg;
            A_LEN:   s_next.rdata = 32'(s_reg.len);
            A_STAT:  s_next.rdata = {14'h0, s_reg.rtid, s_reg.fto,
                        s_reg.ract, s_reg.err, s_reg.done, 1'b0,
                        s_reg.ts};
            A_RXMSK: s_next.rdata = s_reg.rmask;
            A_RXDAT: begin
               s_next.rdata = {24'h0, rx_mem[s_reg.rptr]};
               s_next.rptr  = s_reg.rptr + 1'b1;
            end
            default: s_next.rdata = '0;
         endcase
      end

      // sender
      case (s_reg.ts)
         T_IDLE: begin
            if (start && free) begin
               s_next.ncells   = (nc > 32'd31) ? 5'd31 : nc[4:0];
               s_next.next_new = 6'd1;
               s_next.sent     = '0;
               s_next.retry    = '0;
               s_next.rty      = '0;
               s_next.isent    = '0;
               s_next.done     = 1'b0;
               s_next.err      = 1'b0;
               s_next.tmr      = IACK_CYC;
               s_next.ts       = T_CTX;
               s_next.beat     = '{valid: 1'b1, kind: K_CTX, ar: 1'b1,
                  ie_cnt: 2'd1, tid: s_reg.cfg[F_TID +: 10],
                  has_tid: s_reg.cfg[F_TID +: 10] != 10'h0,
                  fnum: s_next.ncells, ival: ival,
                  default: '0};
            end
         end
         T_CTX: begin
            if (i_rx.valid && i_rx.kind == K_CTXACK
                && i_rx.tid == s_reg.cfg[F_TID +: 10]) begin
               s_next.ts = T_SEL;
            end else if (s_reg.tmr == '0) begin
               if (s_reg.rty >= s_reg.cfg[F_RTY +: 4]) begin
                  s_next.err = 1'b1;
                  s_next.ts  = T_IDLE;
               end else if (free) begin
                  s_next.rty        = s_reg.rty + 1'b1;
                  s_next.tmr        = IACK_CYC;
                  s_next.beat       = s_reg.beat;
                  s_next.beat.valid = 1'b1;
               end
            end else begin
               s_next.tmr = s_reg.tmr - 1'b1;
            end
         end
         T_SEL: begin
            s_next.bi     = '0;
            s_next.crc    = '0;
            s_next.resend = 1'b0;
            if (s_reg.retry != '0 && s_reg.isent < 6'(ival)) begin
               s_next.cur        = pick;
               s_next.retry[pick] = 1'b0;
               s_next.ts         = T_CELL;
            end else if (s_reg.next_new <= 6'(s_reg.ncells)
                         && s_reg.isent < 6'(ival)) begin
               s_next.cur      = s_reg.next_new[4:0];
               s_next.next_new = s_reg.next_new + 1'b1;
               s_next.ts       = T_CELL;
            end else begin
               s_next.tmr = IACK_CYC;
               s_next.ts  = T_WAIT;
            end
         end
         T_CELL: begin
            if (free) begin
               s_next.crc  = crc_byte(s_reg.crc, byt, CRC_POLY, CRC_W);
               s_next.bi   = s_reg.bi + 1'b1;
               s_next.beat = '{valid: 1'b1, kind: K_CELL,
                  tid: s_reg.cfg[F_TID +: 10],
                  has_tid: s_reg.cfg[F_TID +: 10] != 10'h0,
                  fnum: s_reg.cur, ext: 1'b0, data: byt,
                  last: lastb, crc: s_next.crc,
                  default: '0};
               if (lastb) begin
                  s_next.sent[s_reg.cur] = 1'b1;
                  s_next.last_sent = s_reg.cur;
                  s_next.isent = s_reg.isent + {5'h0, !s_reg.resend};
                  s_next.tmr   = IACK_CYC;
                  s_next.ts    = s_reg.resend ? T_WAIT : T_SEL;
               end
            end
         end
         T_WAIT: begin
            if (i_rx.valid && i_rx.kind == K_IACK
                && i_rx.tid == s_reg.cfg[F_TID +: 10]
                && iack_crc(i_rx.iack_mask, i_rx.iack_flags)[15:0]
                   == i_rx.crc[15:0]) begin
               s_next.rty   = '0;
               s_next.isent = '0;
               s_next.retry = s_reg.sent & pres
                              & ~i_rx.iack_flags;
               if (i_rx.iack_mask == 4'h0) begin
                  s_next.err = 1'b1;
                  s_next.ts  = T_IDLE;
               end else if (s_next.retry == '0
                  && s_reg.next_new > 6'(s_reg.ncells)) begin
                  s_next.done = 1'b1;
                  s_next.ts   = T_IDLE;
               end else begin
                  s_next.ts = T_SEL;
               end
            end else if (s_reg.tmr == '0) begin
               if (s_reg.rty >= s_reg.cfg[F_RTY +: 4]) begin
                  s_next.ts = T_ABORT;
               end else begin
                  s_next.rty    = s_reg.rty + 1'b1;
                  s_next.cur    = s_reg.last_sent;
                  s_next.bi     = '0;
                  s_next.crc    = '0;
                  s_next.resend = 1'b1;
                  s_next.ts     = T_CELL;
               end
            end else begin
               s_next.tmr = s_reg.tmr - 1'b1;
            end
         end
         T_ABORT: begin
            if (free) begin
               s_next.beat = '{valid: 1'b1, kind: K_CELL,
                  tid: s_reg.cfg[F_TID +: 10],
                  has_tid: s_reg.cfg[F_TID +: 10] != 10'h0,
                  fnum: ABORT_FNUM, last: 1'b1,
                  default: '0};
               s_next.err  = 1'b1;
               s_next.ts   = T_IDLE;
            end
         end
         default: s_next.ts = T_IDLE;
      endcase

      // receiver: stale transactions die on the fragment timer
      if (s_reg.ract) begin
         if (s_reg.ftmr == '0) begin
            s_next.ract = 1'b0;
            s_next.fto  = 1'b1;
         end else begin
            s_next.ftmr = s_reg.ftmr - 1'b1;
         end
      end
      if (i_rx.valid && i_rx.kind == K_CTX && i_rx.ie_cnt == 2'd1) begin
         s_next.ract  = 1'b1;
         s_next.rtid  = i_rx.tid;
         s_next.rival = (i_rx.ival == 5'h0) ? 5'h1 : i_rx.ival;
         s_next.rtot  = i_rx.fnum;
         s_next.rmask = '0;
         s_next.lack  = '0;
         s_next.rbi   = '0;
         s_next.rcrc  = '0;
         s_next.fto   = 1'b0;
         s_next.ftmr  = FRAG_CYC;
         s_next.resp  = '{valid: 1'b1, kind: K_CTXACK, tid: i_rx.tid,
            has_tid: i_rx.tid != 10'h0, default: '0};
      end else if (i_rx.valid && i_rx.kind == K_CELL && match) begin
         s_next.ftmr = FRAG_CYC;
         if (i_rx.fnum == ABORT_FNUM) begin
            s_next.ract = 1'b0;
         end else begin
            ofs   = (32'(i_rx.fnum) - 32'd1) * 32'(csz)
                    + 32'(s_reg.rbi);
            rx_wa = MEM_AW'(ofs);
            rx_we = ofs < 32'(2**MEM_AW);
            s_next.rbi  = s_reg.rbi + 1'b1;
            s_next.rcrc = rcrc_n;
            if (i_rx.last) begin
               s_next.rbi  = '0;
               s_next.rcrc = '0;
               if (rcrc_n == i_rx.crc) begin
                  s_next.rmask[i_rx.fnum] = 1'b1;
               end
               if (6'(i_rx.fnum) >= s_reg.lack + 6'(s_reg.rival)
                   || i_rx.fnum == s_reg.rtot) begin
                  for (int k = 0; k < 4; k++) begin
                     imask[k] = 2'(k) <= i_rx.fnum[4:3];
                  end
                  iflags      = s_next.rmask & {{8{imask[3]}},
                     {8{imask[2]}}, {8{imask[1]}}, {8{imask[0]}}};
                  s_next.lack = 6'(i_rx.fnum);
                  s_next.resp = '{valid: 1'b1, kind: K_IACK,
                     tid: s_reg.rtid, has_tid: s_reg.rtid != 10'h0,
                     iack_mask: imask, iack_flags: iflags,
                     crc: iack_crc(imask, iflags),
                     default: '0};
               end
            end
         end
      end
   end

   // ****************************************************************
   // registers and buffers
   // ****************************************************************
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_reg     <= '0;
         s_reg.cfg <= CFG_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   // buffers unreset; read only after written
   always_ff @(posedge i_clk_sys) begin
      if (tx_we) begin
         tx_mem[s_reg.wptr] <= i_wdata[7:0];
      end
      if (rx_we) begin
         rx_mem[rx_wa] <= i_rx.data;
      end
   end

   assign o_rdata = s_reg.rdata;
   assign o_tx    = s_reg.beat;
   assign o_resp  = s_reg.resp;

endmodule

// ===== mfe_checker.sv
`timescale 1ns/1ps
module mfe_checker
   import mfe_pkg::*;
(
   input wire logic        i_clk_sys,
   input wire logic        i_rst_n,
   input wire logic [4:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire mfe_frame_s  o_tx,
   input wire logic        i_tx_ready,
   input wire mfe_frame_s  i_rx,
   input wire mfe_frame_s  o_resp
);
   // ****
   // link checks
   // ****
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   // beat kinds named once to keep properties short
   wire cell_o = o_tx.valid && o_tx.kind == K_CELL;
   wire iack_o = o_resp.valid && o_resp.kind == K_IACK;
   wire ctx_i = i_rx.valid && i_rx.kind == K_CTX && i_rx.ie_cnt == 2'h1;
   ctx_flags_a:
      assert property (o_tx.valid && o_tx.kind == K_CTX |->
         o_tx.ar && o_tx.ie_cnt == 2'h1) else $error("bad ctx flags");
   tx_hold_a:
      assert property (o_tx.valid && !i_tx_ready |=>
         o_tx.valid && $stable(o_tx)) else $error("beat dropped");
   cell_hdr_a:
      assert property (cell_o |-> !o_tx.ext &&
         o_tx.has_tid == (o_tx.tid != 10'h0)) else $error("cell header");
   ctx_ack_a:
      assert property (ctx_i |=> o_resp.valid && o_resp.kind == K_CTXACK
         && o_resp.tid == $past(i_rx.tid)) else $error("ctx not acked");
   abort_cell_a:
      assert property (cell_o && o_tx.fnum == ABORT_FNUM |->
         o_tx.last && o_tx.data == 8'h00) else $error("abort cell");
   iack_mask_a:
      assert property (iack_o |-> o_resp.iack_mask inside
         {4'h1, 4'h3, 4'h7, 4'hf}) else $error("iack mask gap");
   iack_cause_a:
      assert property (iack_o |-> $past(i_rx.valid && i_rx.last &&
         i_rx.kind == K_CELL)) else $error("iack without cell");
   term_quiet_a:
      assert property (i_rx.valid && i_rx.kind == K_CELL &&
         i_rx.fnum == ABORT_FNUM |=> !o_resp.valid) else $error("term acked");
   // main scenarios reached
   cover property (ctx_i);
   cover property (iack_o);
   cover property (cell_o && o_tx.fnum == ABORT_FNUM);
endmodule

// ===== mfe_peer.sv
`timescale 1ns/1ps
module mfe_peer
   import mfe_pkg::*;
(
   input  wire logic       i_clk_sys,
   input  wire mfe_frame_s i_tx,
   output      logic       o_ready = 1'b1,
   output      mfe_frame_s o_rx = '0
);
   // ****
   // far-side peer
   // ****
   localparam int W = $bits(mfe_frame_s);
   logic [7:0]  mem [0:63];
   logic [31:0] got;
   logic [15:0] crc = 16'h0, c;
   logic [1:0]  mode;
   mfe_frame_s  f;
   int n_ctx, n_cell, n_abort, drop, lastack, ival, total, stall, k, cyc;
   // msb-first step for cell and ack checks
   function automatic logic [15:0] crcb(logic [15:0] c, logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0);
      return c;
   endfunction
   // one beat; caller releases after the burst
   task automatic put(mfe_frame_s x);
      o_rx <= x;
      @(posedge i_clk_sys);
   endtask
   // released line shows no stale data
   task automatic rel();
      o_rx <= {1'b0, ~o_rx[W-2:0]};
   endtask
   // sink with stall; answers per mode
   always @(posedge i_clk_sys) begin
      cyc++;
      o_ready <= !(stall != 0 && cyc % 3 == 0);
      if (k < 0) begin
         rel();
         k = 0;
      end
      if (i_tx.valid && o_ready) begin
         f = '0;
         f.valid = 1'b1;
         f.tid = i_tx.tid;
         if (i_tx.kind == K_CTX) begin
            n_ctx++;
            total = i_tx.fnum;
            ival = i_tx.ival;
            lastack = 0;
            got = '0;
            f.kind = K_CTXACK;
            if (mode[0]) begin
               o_rx <= f;
               k = -1;
            end
         end else if (i_tx.fnum == ABORT_FNUM)
            n_abort++;
         else begin
            mem[(i_tx.fnum - 1) * 15 + k] = i_tx.data;
            k++;
            crc = crcb(crc, i_tx.data);
            if (i_tx.last) begin
               n_cell++;
               // lost once when commanded, kept when valid
               if (crc == i_tx.crc[15:0] && i_tx.fnum != drop)
                  got[i_tx.fnum] = 1'b1;
               if (i_tx.fnum == drop)
                  drop = 0;
               k = 0;
               crc = 16'h0;
               if (mode[1] && (i_tx.fnum >= lastack + ival ||
                   i_tx.fnum == total)) begin
                  lastack = i_tx.fnum;
                  f.kind = K_IACK;
                  f.iack_mask = 4'hf >> (2'd3 - i_tx.fnum[4:3]);
                  c = crcb(16'h0, {4'h0, f.iack_mask});
                  for (int s = 0; s < 4; s++)
                     if (f.iack_mask[s]) begin
                        f.iack_flags[8*s+:8] = got[8*s+:8];
                        c = crcb(c, got[8*s+:8]);
                     end
                  f.crc = {16'h0, c};
                  o_rx <= f;
                  k = -1;
               end
            end
         end
      end
   end
endmodule

// ===== mfe_engine_tb.sv
`timescale 1ns/1ps
module mfe_engine_tb
   import mfe_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        rst_n, wr, rd, rdy;
   logic [4:0]  addr;
   logic [31:0] wdata, rdata, v;
   mfe_frame_s  tx, rx, resp, last_resp = '0;
   int          n_fail = 0, samples_checked = 0, cyc = 0;
   // ****
   // harness
   // ****
   always #25 clk_sys = ~clk_sys;
   mfe_engine #(.IACK_TIMEOUT_US(1), .FRAG_TIMEOUT_US(2)) mfe_engine_i (
      .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .o_tx(tx), .i_tx_ready(rdy), .i_rx(rx), .o_resp(resp));
   mfe_peer mfe_peer_i (.i_clk_sys(clk_sys), .i_tx(tx), .o_ready(rdy),
      .o_rx(rx));
   // hang guard and answer capture
   always @(posedge clk_sys) begin
      cyc++;
      if (resp.valid)
         last_resp <= resp;
      if (cyc == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic wr_r(logic [4:0] a, logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd_r(logic [4:0] a, output logic [31:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(posedge clk_sys);
      d = rdata;
   endtask
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // send 20 bytes, poll to idle
   task automatic xfer(logic [1:0] m, logic [31:0] cfg, logic [31:0] ctl);
      mfe_peer_i.mode = m;
      mfe_peer_i.n_ctx = 0;
      mfe_peer_i.n_cell = 0;
      wr_r(A_CFG, cfg);
      wr_r(A_LEN, 32'd20);
      for (int i = 0; i < 20; i++)
         wr_r(A_TXDAT, 32'(i + 1));
      wr_r(A_CTRL, ctl);
      v = 32'h1;
      for (int i = 0; i < 400 && v[2:0] != 3'h0; i++)
         rd_r(A_STAT, v);
   endtask
   // beats into the block's receiver
   task automatic send(mfe_kind_e kd, logic [9:0] t, logic [4:0] n, int nb);
      mfe_frame_s f;
      logic [15:0] c;
      f = '0;
      c = 16'h0;
      {f.valid, f.kind, f.ar, f.ie_cnt, f.has_tid} = {1'b1, kd, 4'hb};
      {f.tid, f.fnum, f.ival} = {t, n, 5'h4};
      for (int i = 0; i < nb; i++) begin
         f.data = {n[3:0], 4'(i)};
         c = mfe_peer_i.crcb(c, f.data);
         f.last = (i == nb - 1);
         f.crc = {16'h0, c};
         mfe_peer_i.put(f);
      end
      mfe_peer_i.rel();
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // test sequence
   initial begin
      {rst_n, wr, rd, addr, wdata} = '0;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd_r(A_CFG, v);
      chk(v, CFG_RST);
      rd_r(5'h03, v);
      chk(v, 32'h0);
      // padded frame, stalling sink, last cell lost once
      mfe_peer_i.stall = 1;
      mfe_peer_i.drop = 2;
      xfer(2'h3, 32'ha537_9005, 32'h3);
      chk(v[5:4], 2'b01);
      chk(mfe_peer_i.n_cell, 3);
      chk(mfe_peer_i.mem[14], 8'h0f);
      chk(mfe_peer_i.mem[19], 8'h14);
      chk(mfe_peer_i.mem[29], 8'ha5);
      $display("test 1 done");
      // context never acknowledged
      mfe_peer_i.stall = 0;
      xfer(2'h0, CFG_RST, 32'h1);
      chk({v[5:4], mfe_peer_i.n_ctx[3:0]}, 6'h24);
      chk(mfe_peer_i.n_cell, 0);
      // cells never acknowledged
      xfer(2'h1, CFG_RST, 32'h1);
      chk(v[5:4], 2'b10);
      chk(mfe_peer_i.n_cell, 5);
      chk(mfe_peer_i.n_abort, 1);
      $display("test 2 done");
      // receive: context, good, foreign and termination cells
      send(K_CTX, 10'h9, 5'h2, 1);
      rd_r(A_STAT, v);
      chk(v[17:6], 12'h025);
      chk(last_resp.kind, K_CTXACK);
      send(K_CELL, 10'h9, 5'h1, 15);
      send(K_CELL, 10'ha, 5'h2, 15);
      rd_r(A_RXMSK, v);
      chk(v, 32'h2);
      chk(last_resp.kind, K_CTXACK);
      send(K_CELL, 10'h9, 5'h2, 15);
      rd_r(A_RXMSK, v);
      chk(v, 32'h6);
      chk(last_resp.iack_mask, 4'h1);
      chk(last_resp.iack_flags, 32'h6);
      wr_r(A_RXPTR, 32'd15);
      rd_r(A_RXDAT, v);
      chk(v, 32'h20);
      send(K_CELL, 10'h9, 5'h0, 1);
      rd_r(A_STAT, v);
      chk(v[6], 1'b0);
      send(K_CTX, 10'h3, 5'h2, 1);
      repeat (60) @(posedge clk_sys);
      rd_r(A_STAT, v);
      chk(v[7:6], 2'b10);
      $display("test 3 done");
      tally_and_finish();
   end
endmodule
bind mfe_engine mfe_checker mfe_checker_i (.i_clk_sys(i_clk_sys),
   .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .o_tx(o_tx), .i_tx_ready(i_tx_ready),
   .i_rx(i_rx), .o_resp(o_resp));
